// ===== core/cir_map.svh
`ifndef CIR_MAP_SVH
`define CIR_MAP_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CIR_OFS_STATUS_WORD  8'h00
`define CIR_OFS_IRQ_STAT     8'h04
`define CIR_OFS_IRQ_MASK     8'h08
`define CIR_OFS_LAST_VECTOR  8'h0C
`define CIR_OFS_VEC_BASE     8'h10
// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define CIR_SW_T1            15
`define CIR_SW_T0            14
`define CIR_SW_S             13
`define CIR_SW_M             12
`define CIR_SW_MASK_HI       10
`define CIR_SW_MASK_LO       8
`define CIR_SW_RESET         16'h2700
// ----------------------------------------------------------------
// event bits of the interrupt status register
// ----------------------------------------------------------------
`define CIR_EV_RECOG         0
`define CIR_EV_SPURIOUS      1
`define CIR_EV_AUTOVEC       2
`define CIR_EV_EDGE7         3
`define CIR_EV_W             4
// ----------------------------------------------------------------
// vectors and frame formats
// ----------------------------------------------------------------
`define CIR_VEC_SPURIOUS     8'h18
`define CIR_VEC_AUTO_BASE    8'h18
`define CIR_FMT_NORMAL       4'h0
`define CIR_FMT_THROWAWAY    4'h1
`define CIR_LEVEL_NMI        3'h7
`endif

// ===== core/cir_pkg.sv
`default_nettype none
package cir_pkg;
  // service sequence phases
  typedef enum logic [2:0] {CIR_IDLE, CIR_ACK, CIR_STACK, CIR_STACK2, CIR_FETCH} cir_phase_t;

  // one exception frame pushed on the supervisor stack
  typedef struct packed {
    logic [15:0] offsetWord;   // format in [15:12], vector offset in [11:0]
    logic [31:0] pc;
    logic [15:0] srCopy;
  } cir_frame_t;

  // answer of the interrupt acknowledge cycle
  typedef struct packed {
    logic       done;
    logic       busError;
    logic       selfVectorRequest;
    logic [7:0] vector;
  } cir_ack_t;

  // complete block state
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  prevSample;
    logic [2:0]  validLevel;
    logic [2:0]  validPrev;
    logic        edgeSeven;
    logic        pendingOut;
    logic [15:0] statusWord;
    logic [15:0] srCopy;
    logic [2:0]  svcLevel;
    logic [7:0]  vector;
    cir_phase_t  phase;
    logic        ackReq;
    logic [2:0]  tmLevel;
    logic        push;
    cir_frame_t  frame;
    logic        fetchReq;
    logic [31:0] fetchAddr;
    logic        resume;
    logic [31:0] newPc;
    logic [31:0] savedPc;
    logic [3:0]  evStat;
    logic [3:0]  evMask;
    logic        irq;
    logic [31:0] vecBase;
    logic [31:0] rdData;
  } cir_state_t;
endpackage : cir_pkg
`default_nettype wire

// ===== core/cir_ctrl.sv
// Function
// R1: three active-low lines encode level 0..7, line 0 is the LSB.
// R2: sample every edge; accept a level held unchanged two clock periods.
// R3: requester holds its level until its acknowledge cycle runs.
// R4: valid level strictly above the status mask becomes pending.
// R5: each change from below seven to seven is a new request, unmaskable.
// R6: lowering the mask below a held level retriggers by comparison.
// R7: mask six or seven blocks levels one to six, no re-edge retrigger.
// R8: drive the pending output when a request is made pending.
// R9: on service copy status, set supervisor, stop trace, mask gets level.
// R10: fetch vector by acknowledge cycle, level on transfer modifier outputs.
// R11: self-vector request selects vector 24 plus serviced level.
// R12: bus error during acknowledge makes it spurious, vector 24.
// R13: push offset, next-instruction counter and saved status copy.
// R14: master bit set: clear it, push format 1 frame with supervisor set.
// R15: load counter from selected vector entry, then resume.
// R16: sharing requesters each hold level until their own acknowledge.
// R17: unprogrammed vectoring peripheral usually returns vector 15.
// R18: pending at end of another exception starts interrupt processing at once.
// R19: pending state and output clear once the acknowledge cycle starts.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "cir_map.svh"

module cir_ctrl
(
  // clock and reset
  input  wire  logic                clk,
  input  wire  logic                rst_n,
  // interrupt request lines, active low
  input  wire  logic [2:0]          requestLevelLines_n,
  output var   logic                pendingIndicatorOut_n,
  // processor core handshakes
  input  wire  logic                instBoundary,
  input  wire  logic                exceptionDone,
  input  wire  logic [31:0]         nextPc,
  // interrupt acknowledge cycle
  output var   logic                ackReq,
  output var   logic [2:0]          tmLevel,
  input  wire  cir_pkg::cir_ack_t   ackIn,
  // stack push port
  output var   logic                push,
  output var   cir_pkg::cir_frame_t frame,
  input  wire  logic                pushDone,
  // vector table read port
  output var   logic                fetchReq,
  output var   logic [31:0]         fetchAddr,
  input  wire  logic                fetchDone,
  input  wire  logic [31:0]         fetchData,
  // handler start
  output var   logic                resume,
  output var   logic [31:0]         newPc,
  output var   logic [15:0]         statusWord,
  // register port
  input  wire  logic [7:0]          regAddr,
  input  wire  logic [31:0]         regWrData,
  input  wire  logic                regWr,
  input  wire  logic                regRd,
  output var   logic [31:0]         regRdData,
  output var   logic                irq
);
  import cir_pkg::*;

  cir_state_t st_r;
  cir_state_t st_nxt;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // one combinational process keeps the whole sequence in one place
  always_comb
  begin
    logic [2:0] maskNow;
    logic       levelCmp;
    logic       startSvc;
    logic [2:0] lvl;
    logic [7:0] vec;
    logic [3:0] ev;
    st_nxt   = st_r;
    maskNow  = st_r.statusWord[`CIR_SW_MASK_HI:`CIR_SW_MASK_LO];
    levelCmp = 1'b0;
    startSvc = 1'b0;
    lvl      = 3'h0;
    vec      = 8'h00;
    ev       = 4'h0;
    st_nxt.push     = 1'b0;
    st_nxt.resume   = 1'b0;
    st_nxt.rdData   = 32'h0000_0000;

    // R1: invert the active-low lines so level 0 means no request
    // R2: two-flop synchroniser; sync1 feeds only sync2
    st_nxt.sync1      = ~requestLevelLines_n;
    st_nxt.sync2      = st_r.sync1;
    st_nxt.prevSample = st_r.sync2;
    // R2: accept only when two consecutive samples agree
    if (st_r.sync2 == st_r.prevSample)
    begin
      st_nxt.validLevel = st_r.sync2;
    end
    st_nxt.validPrev = st_r.validLevel;

    // R4: strict comparison; R6 and R7 follow from it being level based
    levelCmp = (st_r.validLevel > maskNow);

    // R5: rising into seven latches a request regardless of mask
    if (st_r.validLevel == `CIR_LEVEL_NMI && st_r.validPrev != `CIR_LEVEL_NMI)
    begin
      st_nxt.edgeSeven = 1'b1;
      ev[`CIR_EV_EDGE7] = 1'b1;
    end

    // R18: a boundary or a finished exception both open the window
    startSvc = (st_r.phase == CIR_IDLE) && st_r.pendingOut && (instBoundary || exceptionDone);
    lvl      = st_r.edgeSeven ? `CIR_LEVEL_NMI : st_r.validLevel;

    // R8: pending shows as soon as a request qualifies while the sequence is idle
    if (st_r.phase == CIR_IDLE && (levelCmp || st_r.edgeSeven))
    begin
      st_nxt.pendingOut = 1'b1;
    end
    else if (st_r.phase == CIR_IDLE && !st_r.edgeSeven)
    begin
      // request withdrawn before service: nothing is pending any more
      st_nxt.pendingOut = 1'b0;
    end

    unique case (st_r.phase)
      CIR_IDLE:
      begin
        if (startSvc)
        begin
          // R9: copy status, supervisor on, trace off, mask to level
          st_nxt.srCopy = st_r.statusWord;
          st_nxt.statusWord[`CIR_SW_S]  = 1'b1;
          st_nxt.statusWord[`CIR_SW_T1] = 1'b0;
          st_nxt.statusWord[`CIR_SW_T0] = 1'b0;
          st_nxt.statusWord[`CIR_SW_MASK_HI:`CIR_SW_MASK_LO] = lvl;
          st_nxt.svcLevel = lvl;
          st_nxt.savedPc  = nextPc;
          // R10: acknowledge cycle carries the level
          st_nxt.ackReq   = 1'b1;
          st_nxt.tmLevel  = lvl;
          // R19: pending clears as the acknowledge cycle starts
          st_nxt.pendingOut = 1'b0;
          if (lvl == `CIR_LEVEL_NMI && !ev[`CIR_EV_EDGE7])
          begin
            st_nxt.edgeSeven = 1'b0;
          end
          ev[`CIR_EV_RECOG] = 1'b1;
          st_nxt.phase = CIR_ACK;
        end
      end
      CIR_ACK:
      begin
        if (ackIn.done)
        begin
          if (ackIn.busError)
          begin
            // R12: spurious interrupt
            vec = `CIR_VEC_SPURIOUS;
            ev[`CIR_EV_SPURIOUS] = 1'b1;
          end
          else if (ackIn.selfVectorRequest)
          begin
            // R11: autovector from the serviced level
            vec = `CIR_VEC_AUTO_BASE + {5'h00, st_r.svcLevel};
            ev[`CIR_EV_AUTOVEC] = 1'b1;
          end
          else
          begin
            // R17: an unprogrammed peripheral's vector is taken as given
            vec = ackIn.vector;
          end
          st_nxt.vector = vec;
          st_nxt.ackReq = 1'b0;
          // R13: first frame with the next-instruction counter
          st_nxt.push  = 1'b1;
          st_nxt.frame = '{offsetWord: {`CIR_FMT_NORMAL, 2'b00, vec, 2'b00},
                           pc: st_r.savedPc, srCopy: st_r.srCopy};
          st_nxt.phase = CIR_STACK;
        end
      end
      CIR_STACK:
      begin
        if (pushDone)
        begin
          if (st_r.statusWord[`CIR_SW_M])
          begin
            // R14: throwaway frame on the interrupt stack
            st_nxt.statusWord[`CIR_SW_M] = 1'b0;
            st_nxt.push  = 1'b1;
            st_nxt.frame.offsetWord[15:12] = `CIR_FMT_THROWAWAY;
            st_nxt.frame.srCopy[`CIR_SW_S] = 1'b1;
            st_nxt.phase = CIR_STACK2;
          end
          else
          begin
            st_nxt.fetchReq  = 1'b1;
            st_nxt.fetchAddr = st_r.vecBase + {22'h00_0000, st_r.vector, 2'b00};
            st_nxt.phase     = CIR_FETCH;
          end
        end
      end
      CIR_STACK2:
      begin
        if (pushDone)
        begin
          st_nxt.fetchReq  = 1'b1;
          st_nxt.fetchAddr = st_r.vecBase + {22'h00_0000, st_r.vector, 2'b00};
          st_nxt.phase     = CIR_FETCH;
        end
      end
      CIR_FETCH:
      begin
        if (fetchDone)
        begin
          // R15: handler address from the vector entry, then run
          st_nxt.fetchReq = 1'b0;
          st_nxt.newPc    = fetchData;
          st_nxt.resume   = 1'b1;
          st_nxt.phase    = CIR_IDLE;
        end
      end
    endcase

    // ------------------------------------------------------------
    // register writes; software status writes only land while idle
    // ------------------------------------------------------------
    if (regWr)
    begin
      case (regAddr)
        `CIR_OFS_STATUS_WORD:
        begin
          if (st_r.phase == CIR_IDLE && !startSvc)
          begin
            // R6: lowering the mask here lets the comparison retrigger
            st_nxt.statusWord = regWrData[15:0];
          end
        end
        `CIR_OFS_IRQ_STAT: st_nxt.evStat = st_r.evStat & ~regWrData[3:0];
        `CIR_OFS_IRQ_MASK: st_nxt.evMask = regWrData[3:0];
        `CIR_OFS_VEC_BASE: st_nxt.vecBase = regWrData;
        default:           st_nxt.vecBase = st_nxt.vecBase;
      endcase
    end
    // new events win over a same-cycle clear
    st_nxt.evStat = st_nxt.evStat | ev;
    st_nxt.irq    = |(st_nxt.evStat & st_nxt.evMask);

    // reads answer one cycle later; unmapped offsets read zero
    if (regRd)
    begin
      case (regAddr)
        `CIR_OFS_STATUS_WORD: st_nxt.rdData = {16'h0000, st_r.statusWord};
        `CIR_OFS_IRQ_STAT:    st_nxt.rdData = {28'h000_0000, st_r.evStat};
        `CIR_OFS_IRQ_MASK:    st_nxt.rdData = {28'h000_0000, st_r.evMask};
        `CIR_OFS_LAST_VECTOR: st_nxt.rdData = {24'h00_0000, st_r.vector};
        `CIR_OFS_VEC_BASE:    st_nxt.rdData = st_r.vecBase;
        default:              st_nxt.rdData = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // synchronous reset; every field takes a constant
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r            <= '0;
      st_r.phase      <= CIR_IDLE;
      st_r.statusWord <= `CIR_SW_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign pendingIndicatorOut_n = ~st_r.pendingOut;
  assign ackReq    = st_r.ackReq;
  assign tmLevel   = st_r.tmLevel;
  assign push      = st_r.push;
  assign frame     = st_r.frame;
  assign fetchReq  = st_r.fetchReq;
  assign fetchAddr = st_r.fetchAddr;
  assign resume    = st_r.resume;
  assign newPc     = st_r.newPc;
  assign statusWord = st_r.statusWord;
  assign regRdData = st_r.rdData;
  assign irq       = st_r.irq;

endmodule : cir_ctrl
`default_nettype wire

// ===== verification/cir_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// interrupt service checker
// ------------------------------------------
module cir_checker
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // watched ports
  input wire logic [2:0]          requestLevelLines_n,
  input wire logic                pendingIndicatorOut_n,
  input wire logic                ackReq,
  input wire logic [2:0]          tmLevel,
  input wire cir_pkg::cir_ack_t   ackIn,
  input wire logic                push,
  input wire cir_pkg::cir_frame_t frame,
  input wire logic [15:0]         statusWord
);
  import cir_pkg::*;
  // all properties share the one clock and reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_ENTRY: assert property ($rose(ackReq) |-> statusWord[15:13] == 3'h1 && statusWord[10:8] == tmLevel)
    else $error("status word wrong at service entry");
  AST_PEND_OFF: assert property ($rose(ackReq) |-> pendingIndicatorOut_n)
    else $error("pending still shown after acknowledge start");
  AST_ACK_END: assert property (ackReq && ackIn.done |=> !ackReq && push)
    else $error("acknowledge not closed by a frame push");
  AST_AUTOVEC: assert property (ackReq && ackIn.done && !ackIn.busError && ackIn.selfVectorRequest
    |=> frame.offsetWord[11:0] == {2'h0, 8'h18 + 8'($past(tmLevel)), 2'h0}) else $error("self vector offset wrong");
  AST_SPUR: assert property (ackReq && ackIn.done && ackIn.busError |=> frame.offsetWord == 16'h0060)
    else $error("spurious offset wrong");
  AST_PUSH: assert property (push |=> !push)
    else $error("push longer than one cycle");
  AST_THROW: assert property (push && frame.offsetWord[15:12] == 4'h1 |-> frame.srCopy[13] && !statusWord[12])
    else $error("throwaway frame status wrong");
  // pending must show within the sync and filter delay unless service started
  AST_NMI: assert property (requestLevelLines_n != 3'h0 ##1 (requestLevelLines_n == 3'h0 && !ackReq) [*7]
    |-> !pendingIndicatorOut_n) else $error("level seven edge not pending");
  cover property ($rose(ackReq) && tmLevel == 3'h7);
  cover property (push && frame.offsetWord[15:12] == 4'h1);
  cover property (ackReq && ackIn.done && ackIn.busError);
endmodule: cir_checker
`default_nettype wire

// ===== verification/cir_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// far side: responder, stack and vector table
// ------------------------------------------
module cir_partner
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // bench controls
  input  wire logic [1:0]        ackMode,
  input  wire logic [7:0]        ackVector,
  input  wire logic [1:0]        slow,
  // design side
  input  wire logic              ackReq,
  input  wire logic              push,
  input  wire logic              fetchReq,
  input  wire logic [31:0]       fetchAddr,
  output var  cir_pkg::cir_ack_t ackIn,
  output var  logic              pushDone,
  output var  logic              fetchDone,
  output var  logic [31:0]       fetchData
);
  import cir_pkg::*;
  logic [1:0] waitCnt_r;
  logic       ackGo;
  logic       fetchGo;
  // answer once the chosen wait runs out
  assign ackGo = ackReq && !ackIn.done && waitCnt_r == slow;
  assign fetchGo = fetchReq && !fetchDone && waitCnt_r == slow;
  // idle data fields flip every cycle so a stale read shows
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {waitCnt_r, ackIn, pushDone, fetchDone, fetchData} <= '0;
    else
    begin
      waitCnt_r <= (ackReq || fetchReq) && waitCnt_r != slow && !ackGo && !fetchGo ? waitCnt_r + 2'h1 : 2'h0;
      // vector, self vector or bus error
      ackIn.done <= ackGo;
      ackIn.busError <= ackGo && ackMode == 2'h2;
      ackIn.selfVectorRequest <= ackGo && ackMode == 2'h1;
      ackIn.vector <= ackGo ? ackVector : ~ackIn.vector;
      pushDone <= push;
      fetchDone <= fetchGo;
      fetchData <= fetchGo ? fetchAddr ^ 32'h5A5A0000 : ~fetchData;
    end
  end
endmodule: cir_partner
`default_nettype wire

// ===== verification/cir_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// interrupt service bench
// ------------------------------------------
module cir_ctrl_tb;
  import cir_pkg::*;
  logic        clk, rst_n, instBoundary, exceptionDone, regWr, regRd, pushDone, fetchDone, irq;
  logic        pendingIndicatorOut_n, ackReq, push, fetchReq, resume;
  logic [2:0]  requestLevelLines_n, tmLevel;
  logic [1:0]  ackMode, slow;
  logic [7:0]  regAddr, ackVector, lastVec;
  logic [15:0] statusWord;
  logic [31:0] nextPc, fetchAddr, fetchData, newPc, regWrData, regRdData, seed, rv;
  cir_ack_t    ackIn;
  cir_frame_t  frame;
  cir_frame_t  fq[$];
  int          errors, samplesChecked;
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  int          tm[9] = '{1, 2, 3, 4, 5, 6, 6, 6, 7};
  int          tl[9] = '{1, 2, 3, 4, 5, 6, 3, 6, 6};
  // design and far side
  cir_ctrl u_dut (.clk(clk), .rst_n(rst_n), .requestLevelLines_n(requestLevelLines_n),
    .pendingIndicatorOut_n(pendingIndicatorOut_n), .instBoundary(instBoundary), .exceptionDone(exceptionDone),
    .nextPc(nextPc), .ackReq(ackReq), .tmLevel(tmLevel), .ackIn(ackIn), .push(push), .frame(frame),
    .pushDone(pushDone), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchDone(fetchDone), .fetchData(fetchData),
    .resume(resume), .newPc(newPc), .statusWord(statusWord), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
  cir_partner u_far (.clk(clk), .rst_n(rst_n), .ackMode(ackMode), .ackVector(ackVector), .slow(slow),
    .ackReq(ackReq), .push(push), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .ackIn(ackIn),
    .pushDone(pushDone), .fetchDone(fetchDone), .fetchData(fetchData));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction: rnd
  task automatic chk(input logic [31:0] got, exp);
    samplesChecked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask: chk
  task automatic complete_run();
    $display("errors %0d compared %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask: complete_run
  task automatic tick();
    @(posedge clk);
    #1;
  endtask: tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {regAddr, regWrData, regWr} <= {a, d, 1'b1};
    @(posedge clk);
    regWr <= 1'b0;
  endtask: wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdData;
  endtask: rd
  // collect every frame pushed by the service in flight
  always @(posedge clk)
    if (push === 1'b1)
      fq.push_back(frame);
  // one full service; md 0 vector, 1 self vector, 2 bus error, 3 unprogrammed vector
  task automatic svc(input int lv, md, msk, keep);
    logic        m;
    logic        e7;
    logic [15:0] sr;
    logic [31:0] npc, vb;
    m = 1'(rnd());
    sr = {3'h4, m, 1'b0, 3'(msk), 8'h00};
    vb = rnd() & 32'hFFFF_FC00;
    npc = rnd() & 32'hFFFF_FFFC;
    lastVec = md == 3 ? 8'h0F : 8'(rnd());
    fq.delete();
    wr(8'h04, 32'hF);
    wr(8'h10, vb);
    wr(8'h00, {16'h0, sr});
    {ackMode, ackVector, slow, nextPc} <= {2'(md % 3), lastVec, 2'(rnd()), npc};
    // a rise into seven from any lower level must log the edge event
    e7 = lv == 7 && requestLevelLines_n != 3'h0;
    requestLevelLines_n <= ~3'(lv);
    lastVec = md == 2 ? 8'h18 : md == 1 ? 8'h18 + 8'(lv) : lastVec;
    repeat (10) @(posedge clk);
    #1 chk(pendingIndicatorOut_n, 0);
    @(posedge clk);
    {instBoundary, exceptionDone} <= lv % 2 ? 2'h2 : 2'h1;
    for (int n = 0; n < 20 && ackReq !== 1'b1; n++) tick();
    chk(tmLevel, lv);
    chk({statusWord[15:13], statusWord[10:8]}, {3'h1, 3'(lv)});
    chk(pendingIndicatorOut_n, 1);
    @(posedge clk);
    {instBoundary, exceptionDone} <= 2'h0;
    if (!keep) requestLevelLines_n <= 3'h7;
    for (int n = 0; n < 60 && resume !== 1'b1; n++) tick();
    chk(resume, 1);
    chk(newPc, (vb + {22'h0, lastVec, 2'h0}) ^ 32'h5A5A0000);
    chk(fq.size(), m + 1);
    foreach (fq[i])
    begin
      chk({fq[i].offsetWord, fq[i].srCopy}, {4'(i), 2'h0, lastVec, 2'h0, sr | (i ? 16'h2000 : 16'h0)});
      chk(fq[i].pc, npc);
    end
    chk({statusWord[15:12], statusWord[10:8]}, {4'h2, 3'(lv)});
    rd(8'h0C);
    chk(rv, lastVec);
    rd(8'h04);
    chk(rv[3:0], {e7, md == 1, md == 2, 1'b1});
    chk(irq, 1);
  endtask: svc
  // main sequence
  initial
  begin
    seed = 32'h0001022A;
    {rst_n, instBoundary, exceptionDone, regWr, regRd, ackMode, slow, regAddr, ackVector} = '0;
    {nextPc, regWrData, requestLevelLines_n} = {64'h0, 3'h7};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk(statusWord, 32'h2700);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(rv, ra[i] ? 32'h0 : 32'h2700);
    end
    wr(8'h08, 32'hF);
    for (int lv = 1; lv < 8; lv++) svc(lv, lv % 3, 0, 0);
    svc(5, 3, 2, 0);
    svc(7, 0, 7, 0);
    svc(7, 1, 7, 1);
    repeat (10) @(posedge clk);
    #1 chk(pendingIndicatorOut_n, 1);
    svc(7, 2, 6, 0);
    foreach (tm[i])
    begin
      wr(8'h00, 32'h2000 | (tm[i] << 8));
      requestLevelLines_n <= ~3'(tl[i]);
      repeat (10) @(posedge clk);
      #1 chk(pendingIndicatorOut_n, 1);
    end
    svc(6, 0, 5, 0);
    wr(8'h08, 32'h0);
    repeat (2) tick();
    chk(irq, 0);
    wr(8'h08, 32'hF);
    repeat (2) tick();
    chk(irq, 1);
    wr(8'h04, 32'hF);
    repeat (2) tick();
    chk(irq, 0);
    wr(8'h0C, 32'hFF);
    rd(8'h0C);
    chk(rv, lastVec);
    complete_run();
  end
  // watchdog, over thirty times the expected run
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
endmodule: cir_ctrl_tb
bind cir_ctrl cir_checker u_chk (.clk(clk), .rst_n(rst_n), .requestLevelLines_n(requestLevelLines_n),
  .pendingIndicatorOut_n(pendingIndicatorOut_n), .ackReq(ackReq), .tmLevel(tmLevel), .ackIn(ackIn),
  .push(push), .frame(frame), .statusWord(statusWord));
`default_nettype wire
